// *** logic/rh_status_pkg.sv ***
// Constants and carriers for the root hub status register block.
// Assumes a host command port with 8-bit command codes and 32-bit data.
package rh_status_pkg;
	// ==========================================
	// Command codes
	localparam logic [7:0] CMD_RH_STATUS_READ = 8'h14; // Read code
	localparam logic [7:0] CMD_RH_STATUS_WRITE = 8'h94; // Write code
	// ==========================================
	// Bit positions
	localparam int BIT_CLEAR_WAKE = 31; // Clear wake enable strobe
	localparam int BIT_OC_CHANGE = 17; // Overcurrent change flag
	localparam int BIT_SET_POWER = 16; // Local power change / set global
	localparam int BIT_WAKE_EN = 15; // Remote wake-up enable
	localparam int BIT_OC = 1; // Hub overcurrent indicator
	localparam int BIT_CLR_POWER = 0; // Local power / clear global
	// ==========================================
	// Reset values
	localparam logic RST_FLAG = 1'h0; // All stored flags start clear
	// ==========================================
	// Host command carrier
	typedef struct packed
	{
		logic rd; // Read strobe
		logic wr; // Write strobe
		logic [7:0] code; // Command code
		logic [31:0] wdata; // Write data
	} host_cmd_s;
endpackage

// *** logic/root_hub_status_power_control.sv ***
// Root hub status register: overcurrent, wake enable and power commands.
// Assumes synchronous command strobes and per-port signals on i_clk.
// How it works
// R01: Writing 1 to bit 31 clears wake enable
// R02: Overcurrent indicator change sets bit 17 flag
// R03: Change flag clears only on written 1
// R04: Bits 16 and 0 read as zero
// R05: Global mode bit16 write powers all ports
// R06: Per-port mode bit16 powers unmasked ports only
// R07: Global mode bit0 write unpowers all ports
// R08: Per-port mode bit0 unpowers unmasked ports only
// R09: Bit 15 reads wake enable; gates wake events
// R10: Enabled connect change while suspended triggers resume and interrupt
// R11: Writing 1 to bit 15 sets wake enable
// R12: Bit 1 reports hub-wide overcurrent
// R13: Per-port overcurrent reporting reads bit 1 zero
// R14: Software writes reserved bits as zero
// R15: Masked ports ignore global power commands in per-port mode
// R16: Read code 14, write code 94
// R17: Bit 31 reads as zero
// R18: Reset clears indicator, change flag, wake enable
`timescale 1ns/1ns
module root_hub_status_power_control
#(
	parameter int NUM_PORTS = 2 // Downstream ports
)
(
	input wire logic i_clk, // Controller clock
	input wire logic i_reset, // Sync reset, high
	input wire rh_status_pkg::host_cmd_s i_cmd, // Host command
	input wire logic i_power_switching_mode, // 0 global, 1 per-port
	input wire logic i_per_port_oc_mode, // 1 overcurrent per port
	input wire logic i_global_oc, // Raw hub overcurrent
	input wire logic [NUM_PORTS-1:0] i_port_power_control_mask, // Mask per port
	input wire logic [NUM_PORTS-1:0] i_connect_change, // Connect change pulses
	input wire logic i_suspended, // Controller in suspend
	output logic [31:0] o_rdata, // Read data
	output logic o_rvalid, // Read data valid
	output logic [NUM_PORTS-1:0] o_port_power_on, // Per-port power-on pulse
	output logic [NUM_PORTS-1:0] o_port_power_off, // Per-port power-off pulse
	output logic o_resume_request // Resume and resume-detected pulse
);
	// ==========================================
	// Elaboration check
	if (NUM_PORTS < 1 || NUM_PORTS > 2)
	begin : g_bad_ports
		$error("NUM_PORTS must be 1 or 2");
	end

	// ==========================================
	// State
	logic hub_overcurrent_indicator; // Filtered indicator
	logic overcurrent_change_flag; // Sticky change flag
	logic remote_wakeup_enable; // Wake enable flag
	logic wr_hit; // Write command to this register
	logic [NUM_PORTS-1:0] port_sel; // Ports that follow global commands
	logic next_hub_overcurrent_indicator; // Indicator value next cycle

	assign wr_hit = i_cmd.wr && (i_cmd.code == rh_status_pkg::CMD_RH_STATUS_WRITE); // R16
	// Per-port reporting forces the hub indicator low
	assign next_hub_overcurrent_indicator = i_per_port_oc_mode ? 1'h0 : i_global_oc; // R12 R13

	// Indicator register
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			hub_overcurrent_indicator <= rh_status_pkg::RST_FLAG; // R18
		else
			hub_overcurrent_indicator <= next_hub_overcurrent_indicator; // R12
	end

	// Change flag: set beats clear so no edge is lost
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			overcurrent_change_flag <= rh_status_pkg::RST_FLAG; // R18
		else if (next_hub_overcurrent_indicator != hub_overcurrent_indicator)
			overcurrent_change_flag <= 1'h1; // R02
		else if (wr_hit && i_cmd.wdata[rh_status_pkg::BIT_OC_CHANGE])
			overcurrent_change_flag <= 1'h0; // R03
	end

	// Wake enable: clear strobe wins if both written together
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			remote_wakeup_enable <= rh_status_pkg::RST_FLAG; // R18
		else if (wr_hit && i_cmd.wdata[rh_status_pkg::BIT_CLEAR_WAKE])
			remote_wakeup_enable <= 1'h0; // R01
		else if (wr_hit && i_cmd.wdata[rh_status_pkg::BIT_WAKE_EN])
			remote_wakeup_enable <= 1'h1; // R11
	end

	// Ports touched by global commands
	genvar gi;
	for (gi = 0; gi < NUM_PORTS; gi++)
	begin : g_sel
		// Global mode: every port; per-port mode: unmasked only
		assign port_sel[gi] = !i_power_switching_mode || !i_port_power_control_mask[gi]; // R05 R06 R15
	end

	// Power command pulses
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			o_port_power_on <= '0;
			o_port_power_off <= '0;
		end
		else
		begin
			o_port_power_on <= (wr_hit && i_cmd.wdata[rh_status_pkg::BIT_SET_POWER]) ? port_sel : '0; // R05 R06
			o_port_power_off <= (wr_hit && i_cmd.wdata[rh_status_pkg::BIT_CLR_POWER]) ? port_sel : '0; // R07 R08
		end
	end

	// Remote wake-up resume trigger
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			o_resume_request <= 1'h0;
		else
			o_resume_request <= remote_wakeup_enable && i_suspended && (|i_connect_change); // R09 R10
	end

	// Read port; unsupported and strobe bits read zero
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			o_rdata <= '0;
			o_rvalid <= 1'h0;
		end
		else
		begin
			o_rvalid <= i_cmd.rd && (i_cmd.code == rh_status_pkg::CMD_RH_STATUS_READ); // R16
			o_rdata <= '0; // R04 R17
			o_rdata[rh_status_pkg::BIT_OC_CHANGE] <= overcurrent_change_flag;
			o_rdata[rh_status_pkg::BIT_WAKE_EN] <= remote_wakeup_enable; // R09
			o_rdata[rh_status_pkg::BIT_OC] <= hub_overcurrent_indicator; // R12
		end
	end

	// ==========================================
	// Assertions
	// Reset leaves all three stored flags clear
	reset_clears_a: assert property ( // R18
		@(posedge i_clk)
		i_reset |=> (!hub_overcurrent_indicator && !overcurrent_change_flag && !remote_wakeup_enable))
		else $error("flag not cleared by reset");

	// Any change of the indicator raises the flag one cycle later
	change_sets_flag_a: assert property ( // R02
		@(posedge i_clk) disable iff (i_reset)
		(next_hub_overcurrent_indicator != hub_overcurrent_indicator) |=> overcurrent_change_flag)
		else $error("change flag not set");

	// Flag holds until a written 1 clears it
	flag_sticky_a: assert property ( // R03
		@(posedge i_clk) disable iff (i_reset)
		(overcurrent_change_flag && !(wr_hit && i_cmd.wdata[rh_status_pkg::BIT_OC_CHANGE]))
		|=> overcurrent_change_flag)
		else $error("change flag dropped");

	// Clear strobe always drops the wake enable
	wake_clear_a: assert property ( // R01
		@(posedge i_clk) disable iff (i_reset)
		(wr_hit && i_cmd.wdata[rh_status_pkg::BIT_CLEAR_WAKE]) |=> !remote_wakeup_enable)
		else $error("wake enable not cleared");

	// Set strobe raises the wake enable unless cleared alongside
	wake_set_a: assert property ( // R11
		@(posedge i_clk) disable iff (i_reset)
		(wr_hit && i_cmd.wdata[rh_status_pkg::BIT_WAKE_EN] && !i_cmd.wdata[rh_status_pkg::BIT_CLEAR_WAKE])
		|=> remote_wakeup_enable)
		else $error("wake enable not set");

	// Unsupported status bits and the strobe bit never read back
	read_zero_bits_a: assert property ( // R04 R17
		@(posedge i_clk) disable iff (i_reset)
		o_rvalid |-> (o_rdata[rh_status_pkg::BIT_SET_POWER] == 1'h0
		&& o_rdata[rh_status_pkg::BIT_CLR_POWER] == 1'h0
		&& o_rdata[rh_status_pkg::BIT_CLEAR_WAKE] == 1'h0))
		else $error("zero bits read nonzero");

	// Read word carries the wake enable as it stood when taken
	wake_read_a: assert property ( // R09
		@(posedge i_clk) disable iff (i_reset)
		o_rvalid |-> (o_rdata[rh_status_pkg::BIT_WAKE_EN] == $past(remote_wakeup_enable)))
		else $error("wake enable misread");

	// Read word carries the indicator as it stood when taken
	oc_read_a: assert property ( // R12
		@(posedge i_clk) disable iff (i_reset)
		o_rvalid |-> (o_rdata[rh_status_pkg::BIT_OC] == $past(hub_overcurrent_indicator)))
		else $error("indicator misread");

	// Read word carries the change flag as it stood when taken
	flag_read_a: assert property ( // R02
		@(posedge i_clk) disable iff (i_reset)
		o_rvalid |-> (o_rdata[rh_status_pkg::BIT_OC_CHANGE] == $past(overcurrent_change_flag)))
		else $error("change flag misread");

	// Global reporting: indicator trails the raw input by one cycle
	indicator_follows_a: assert property ( // R12
		@(posedge i_clk) disable iff (i_reset)
		!i_per_port_oc_mode |=> (hub_overcurrent_indicator == $past(i_global_oc)))
		else $error("indicator does not follow input");

	// Per-port reporting keeps the hub indicator low
	oc_per_port_a: assert property ( // R13
		@(posedge i_clk) disable iff (i_reset)
		i_per_port_oc_mode |=> !hub_overcurrent_indicator)
		else $error("indicator set in per-port mode");

	// Global set power reaches every port
	global_on_a: assert property ( // R05
		@(posedge i_clk) disable iff (i_reset)
		(wr_hit && i_cmd.wdata[rh_status_pkg::BIT_SET_POWER] && !i_power_switching_mode) |=> (&o_port_power_on))
		else $error("global power-on missed a port");

	// Global clear power reaches every port
	global_off_a: assert property ( // R07
		@(posedge i_clk) disable iff (i_reset)
		(wr_hit && i_cmd.wdata[rh_status_pkg::BIT_CLR_POWER] && !i_power_switching_mode) |=> (&o_port_power_off))
		else $error("global power-off missed a port");

	// Per-port mode: masked ports never see a global power-on
	masked_on_a: assert property ( // R06 R15
		@(posedge i_clk) disable iff (i_reset)
		(i_power_switching_mode && wr_hit) |=> ((o_port_power_on & $past(i_port_power_control_mask)) == '0))
		else $error("masked port powered on");

	// Per-port mode: masked ports never see a global power-off
	masked_off_a: assert property ( // R08 R15
		@(posedge i_clk) disable iff (i_reset)
		(i_power_switching_mode && wr_hit) |=> ((o_port_power_off & $past(i_port_power_control_mask)) == '0))
		else $error("masked port powered off");

	// No set-power bit written, no power-on pulse
	on_needs_write_a: assert property ( // R05 R06
		@(posedge i_clk) disable iff (i_reset)
		!(wr_hit && i_cmd.wdata[rh_status_pkg::BIT_SET_POWER]) |=> (o_port_power_on == '0))
		else $error("stray power-on pulse");

	// No clear-power bit written, no power-off pulse
	off_needs_write_a: assert property ( // R07 R08
		@(posedge i_clk) disable iff (i_reset)
		!(wr_hit && i_cmd.wdata[rh_status_pkg::BIT_CLR_POWER]) |=> (o_port_power_off == '0))
		else $error("stray power-off pulse");

	// Enabled connect change while suspended requests resume
	wake_resume_a: assert property ( // R10
		@(posedge i_clk) disable iff (i_reset)
		(remote_wakeup_enable && i_suspended && (|i_connect_change)) |=> o_resume_request)
		else $error("resume not requested");

	// Without wake enable a connect change is no wake event
	wake_gates_resume_a: assert property ( // R09
		@(posedge i_clk) disable iff (i_reset)
		!remote_wakeup_enable |=> !o_resume_request)
		else $error("resume without wake enable");
endmodule

// *** dv/testbench.sv ***
// Self-checking bench for the root hub status register block.
// Assumes the host command port and per-port signals share i_clk.
`timescale 1ns/1ns
module testbench;
	logic i_clk; // Controller clock
	logic i_reset; // Sync reset
	rh_status_pkg::host_cmd_s cmd; // Host command
	logic psm; // Power switching mode
	logic ppoc; // Per-port overcurrent mode
	logic goc; // Raw hub overcurrent
	logic [1:0] mask; // Power control mask
	logic [1:0] conn; // Connect change events
	logic susp; // Suspend level
	logic [31:0] o_rdata; // Read data
	logic o_rvalid; // Read valid
	logic [1:0] pon; // Power-on pulses
	logic [1:0] poff; // Power-off pulses
	logic res; // Resume pulse
	int errors; // Mismatch count
	int total_checks; // Comparison count
	root_hub_status_power_control #(.NUM_PORTS(2)) i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_cmd(cmd),
		.i_power_switching_mode(psm), .i_per_port_oc_mode(ppoc), .i_global_oc(goc),
		.i_port_power_control_mask(mask), .i_connect_change(conn), .i_suspended(susp), .o_rdata(o_rdata),
		.o_rvalid(o_rvalid), .o_port_power_on(pon), .o_port_power_off(poff), .o_resume_request(res));
	// ==========================================
	// Clock
	initial
	begin
		i_clk = 1'h0;
		forever #2 i_clk = ~i_clk;
	end
	// Compare and count; four-state equality keeps unknowns visible
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask
	// Verdict and end of run
	task automatic summarize;
		if (errors == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// One command cycle; outputs settle after the taking edge
	task automatic cmd_op(input logic rd, input logic [31:0] wdata);
		@(posedge i_clk);
		cmd <= '{rd: rd, wr: !rd, code: rd ? rh_status_pkg::CMD_RH_STATUS_READ : rh_status_pkg::CMD_RH_STATUS_WRITE,
			wdata: wdata};
		@(posedge i_clk);
		cmd <= '0;
		#1;
	endtask
	// Read with expected word
	task automatic rd(input logic [31:0] exp);
		cmd_op(1'h1, 32'h0);
		check({31'h0, o_rvalid}, 32'h1);
		check(o_rdata, exp);
	endtask
	// Write; also checks power pulses {on, off}, so stray pulses are caught
	task automatic wr(input logic [31:0] data, input logic [3:0] pwr);
		cmd_op(1'h0, data);
		check({28'h0, pon, poff}, {28'h0, pwr});
	endtask
	// Connect change pulse on port 0 with expected resume
	task automatic connect(input logic exp);
		@(posedge i_clk);
		conn <= 2'h1;
		@(posedge i_clk);
		conn <= 2'h0;
		#1;
		check({31'h0, res}, {31'h0, exp});
	endtask
	// ==========================================
	// Main sequence
	initial
	begin
		errors = 0;
		total_checks = 0;
		{cmd, psm, ppoc, goc, mask, conn, susp} <= '0;
		i_reset <= 1'h1;
		repeat (16) @(posedge i_clk);
		i_reset <= 1'h0;
		rd(32'h0);
		wr(32'h0000_8000, 4'h0);
		rd(32'h0000_8000);
		wr(32'h0, 4'h0);
		rd(32'h0000_8000);
		@(posedge i_clk) susp <= 1'h1;
		connect(1'h1);
		wr(32'h8000_0000, 4'h0);
		rd(32'h0);
		connect(1'h0);
		// Overcurrent indicator and its change flag
		@(posedge i_clk) goc <= 1'h1;
		repeat (3) @(posedge i_clk);
		rd(32'h0002_0002);
		wr(32'h0, 4'h0);
		rd(32'h0002_0002);
		wr(32'h0002_0000, 4'h0);
		rd(32'h0000_0002);
		@(posedge i_clk) ppoc <= 1'h1;
		repeat (3) @(posedge i_clk);
		rd(32'h0002_0000);
		// Power commands, global then per-port with port 0 masked
		wr(32'h0001_0000, 4'hc);
		wr(32'h0000_0001, 4'h3);
		@(posedge i_clk);
		psm <= 1'h1;
		mask <= 2'h1;
		wr(32'h0001_0000, 4'h8);
		wr(32'h0000_0001, 4'h2);
		// Mid-run reset with wake enable and change flag both set
		wr(32'h0000_8000, 4'h0);
		rd(32'h0002_8000);
		@(posedge i_clk) i_reset <= 1'h1;
		repeat (2) @(posedge i_clk);
		i_reset <= 1'h0;
		rd(32'h0);
		summarize();
	end
	// Watchdog: the sequence needs well under 300 cycles
	initial
	begin
		repeat (2000) @(posedge i_clk);
		errors++;
		summarize();
	end
endmodule
